// ---- common/annp_pkg.sv ----
// annp_pkg: register map, field positions and reset values for the
// next page register subset of one port.
// assumes a 5-bit management register address and 16-bit data.
package annp_pkg;
    localparam logic [4:0]  ADDR_PARTNER_NP   = 5'h05;
    localparam logic [4:0]  ADDR_EXPANSION    = 5'h06;
    localparam logic [4:0]  ADDR_NP_TRANSMIT  = 5'h07;
    localparam int          BIT_MORE_PAGES    = 15;
    localparam int          BIT_ACK           = 14;
    localparam int          BIT_MSG_PAGE      = 13;
    localparam int          BIT_COMPLY        = 12;
    localparam int          BIT_TOGGLE        = 11;
    localparam int          CODE_MSB          = 10;
    localparam int          BIT_PD_FAULT      = 4;
    localparam int          BIT_PARTNER_NPA   = 3;
    localparam int          BIT_LOCAL_NPA     = 2;
    localparam int          BIT_PAGE_RX       = 1;
    localparam int          BIT_PARTNER_ANA   = 0;
    localparam logic [15:0] NP_TRANSMIT_RESET = 16'h2001;
    localparam logic [15:0] NP_TRANSMIT_WMASK = 16'hBFFF;
    localparam logic [15:0] PARTNER_RESET     = 16'h0000;
endpackage : annp_pkg

// ---- rtl/annp_sync3.sv ----
// annp_sync3: three-stage synchroniser for one asynchronous level.
// assumes clk, rst and clock enable of the register bank.
`timescale 1ns/10ps
module annp_sync3 (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic clkEn,
    input  wire logic asyncIn,
    output logic      syncOut
);
    logic [2:0] stage_ff;

    // change only counted once the last two stages agree
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            stage_ff <= 3'h0;
            syncOut  <= 1'b0;
        end else if (clkEn) begin
            stage_ff <= {stage_ff[1:0], asyncIn};
            if (stage_ff[2] == stage_ff[1]) begin
                syncOut <= stage_ff[2];
            end
        end
    end
endmodule : annp_sync3

// ---- rtl/annp_regs.sv ----
// annp_regs: next page register bank of one port (received page view,
// expansion status, transmit next page).
// assumes negotiation logic on clk drives the page and event inputs;
// the parallel detect fault arrives asynchronously from the media side.
`timescale 1ns/10ps
module annp_regs (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        clkEn,
    input  wire logic [4:0]  regAddr,
    input  wire logic        regRd,
    input  wire logic        regWr,
    input  wire logic [15:0] regWrData,
    output logic [15:0]      regRdData,
    input  wire logic        pageLoad,
    input  wire logic [15:0] pageWord,
    input  wire logic        pageIsNext,
    input  wire logic        partnerNpAble,
    input  wire logic        partnerAnAble,
    input  wire logic        pdFaultAsync,
    input  wire logic        txToggleLoad,
    input  wire logic        txToggleValue,
    output logic [15:0]      npTransmitWord,
    output logic             partnerWordIsNext
);
    logic [15:0] partnerWord_ff;
    logic        pageIsNext_ff;
    logic        pdFault_ff;
    logic        pageRx_ff;
    logic        partnerNpa_ff;
    logic        partnerAna_ff;
    logic        moreNpFlag_ff;
    logic        msgPageSelect_ff;
    logic        complyAck_ff;
    logic        txToggle_ff;
    logic [10:0] txCode_ff;
    logic [15:0] npTxWord;
    logic        txWrite;
    logic        pageLoadEn;
    logic        pdRise;
    localparam logic [15:0] TX_RST = annp_pkg::NP_TRANSMIT_RESET;
    logic        pdFaultSync;
    logic        pdFaultPrev_ff;
    logic [15:0] nxt_rdData;
    logic        expRead;

    function automatic logic hit(input logic [4:0] a, input logic [4:0] r);
        return a == r;
    endfunction : hit

    // expansion view; local next page ability is hardwired
    function automatic logic [15:0] pack_expansion(input logic pd,
                                                   input logic npa,
                                                   input logic rx,
                                                   input logic ana);
        logic [15:0] v;
        v = 16'h0000;
        v[annp_pkg::BIT_PD_FAULT]    = pd;
        v[annp_pkg::BIT_PARTNER_NPA] = npa;
        v[annp_pkg::BIT_LOCAL_NPA]   = 1'b1;
        v[annp_pkg::BIT_PAGE_RX]     = rx;
        v[annp_pkg::BIT_PARTNER_ANA] = ana;
        return v;
    endfunction : pack_expansion

    annp_sync3 u_pd_sync (
        .clk     (clk),
        .rst     (rst),
        .clkEn   (clkEn),
        .asyncIn (pdFaultAsync),
        .syncOut (pdFaultSync)
    );

    assign expRead = regRd && hit(regAddr, annp_pkg::ADDR_EXPANSION);
    assign txWrite = clkEn && regWr && hit(regAddr, annp_pkg::ADDR_NP_TRANSMIT);
    assign pageLoadEn = clkEn && pageLoad;
    assign pdRise = pdFaultSync && !pdFaultPrev_ff;

    // received page store; layout flag follows each load
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            partnerWord_ff <= annp_pkg::PARTNER_RESET;
            pageIsNext_ff  <= 1'b0;
        end else if (clkEn && pageLoad) begin
            partnerWord_ff <= pageWord;
            pageIsNext_ff  <= pageIsNext;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            partnerNpa_ff <= 1'b0;
        end else if (clkEn) begin
            partnerNpa_ff <= partnerNpAble;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            partnerAna_ff <= 1'b0;
        end else if (clkEn) begin
            partnerAna_ff <= partnerAnAble;
        end
    end

    // latched flags: a set in the read cycle wins over the clear
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pdFault_ff     <= 1'b0;
            pdFaultPrev_ff <= 1'b0;
        end else if (clkEn) begin
            pdFaultPrev_ff <= pdFaultSync;
            if (pdRise) begin
                pdFault_ff <= 1'b1;
            end else if (expRead) begin
                pdFault_ff <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pageRx_ff <= 1'b0;
        end else if (pageLoadEn) begin
            pageRx_ff <= 1'b1;
        end else if (clkEn && expRead) begin
            pageRx_ff <= 1'b0;
        end
    end

    // transmit page fields, one register per field
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            moreNpFlag_ff <= TX_RST[annp_pkg::BIT_MORE_PAGES];
        end else if (txWrite) begin
            moreNpFlag_ff <= regWrData[annp_pkg::BIT_MORE_PAGES];
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            msgPageSelect_ff <= TX_RST[annp_pkg::BIT_MSG_PAGE];
        end else if (txWrite) begin
            msgPageSelect_ff <= regWrData[annp_pkg::BIT_MSG_PAGE];
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            complyAck_ff <= TX_RST[annp_pkg::BIT_COMPLY];
        end else if (txWrite) begin
            complyAck_ff <= regWrData[annp_pkg::BIT_COMPLY];
        end
    end

    // a management write wins over the engine's toggle update
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            txToggle_ff <= TX_RST[annp_pkg::BIT_TOGGLE];
        end else if (txWrite) begin
            txToggle_ff <= regWrData[annp_pkg::BIT_TOGGLE];
        end else if (clkEn && txToggleLoad) begin
            txToggle_ff <= txToggleValue;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            txCode_ff <= TX_RST[annp_pkg::CODE_MSB:0];
        end else if (txWrite) begin
            txCode_ff <= regWrData[annp_pkg::CODE_MSB:0];
        end
    end

    // reserved bit 14 is never stored, so it always reads zero
    always_comb begin
        npTxWord = 16'h0000;
        npTxWord[annp_pkg::BIT_MORE_PAGES] = moreNpFlag_ff;
        npTxWord[annp_pkg::BIT_MSG_PAGE]   = msgPageSelect_ff;
        npTxWord[annp_pkg::BIT_COMPLY]     = complyAck_ff;
        npTxWord[annp_pkg::BIT_TOGGLE]     = txToggle_ff;
        npTxWord[annp_pkg::CODE_MSB:0]     = txCode_ff;
    end

    // reserved and unmapped addresses read zero, writes ignored
    always_comb begin
        nxt_rdData = 16'h0000;
        if (hit(regAddr, annp_pkg::ADDR_PARTNER_NP)) begin
            nxt_rdData = partnerWord_ff;
        end else if (hit(regAddr, annp_pkg::ADDR_EXPANSION)) begin
            nxt_rdData = pack_expansion(pdFault_ff, partnerNpa_ff,
                                        pageRx_ff, partnerAna_ff);
        end else if (hit(regAddr, annp_pkg::ADDR_NP_TRANSMIT)) begin
            nxt_rdData = npTxWord;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            regRdData <= 16'h0000;
        end else if (clkEn && regRd) begin
            regRdData <= nxt_rdData;
        end
    end

    assign npTransmitWord    = npTxWord;
    assign partnerWordIsNext = pageIsNext_ff;
endmodule : annp_regs

// ---- tb/annp_monitor.sv ----
// annp_monitor: port checks for the next page register bank
// assumes bind to annp_regs; reads answer one edge after regRd
`timescale 1ns/10ps
module annp_monitor (
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        clkEn,
    input wire logic [4:0]  regAddr,
    input wire logic        regRd,
    input wire logic        regWr,
    input wire logic [15:0] regWrData,
    input wire logic [15:0] regRdData,
    input wire logic        pageLoad,
    input wire logic [15:0] pageWord,
    input wire logic        pageIsNext,
    input wire logic [15:0] npTransmitWord,
    input wire logic        partnerWordIsNext
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    wire ld  = clkEn && pageLoad;
    wire rd5 = clkEn && regRd && regAddr == 5'h05 && !pageLoad;
    wire rd6 = clkEn && regRd && regAddr == 5'h06 && !pageLoad;
    wire wr7 = clkEn && regWr && regAddr == 5'h07;
    a_local_able: assert property (rd6 |=> regRdData[2])
        else $error("local able low");
    a_bit14_zero: assert property (!npTransmitWord[14])
        else $error("bit 14 set");
    a_tx_write: assert property (wr7 |=>
        npTransmitWord == ($past(regWrData) & 16'hBFFF)) else $error("tx");
    a_layout_flag: assert property (ld |=>
        partnerWordIsNext == $past(pageIsNext)) else $error("layout");
    a_page_view: assert property (ld ##1 rd5 |=>
        regRdData == $past(pageWord, 2)) else $error("page view");
    a_rx_set: assert property (ld ##1 rd6 |=> regRdData[1])
        else $error("rx not set");
    a_rx_clear: assert property (rd6 ##1 rd6 |=> !regRdData[1])
        else $error("rx not cleared");
    a_unmapped_zero: assert property (clkEn && regRd && regAddr == 5'h00
        |=> regRdData == 16'h0000) else $error("unmapped read");
endmodule : annp_monitor
bind annp_regs annp_monitor annp_monitor_inst (.*);

// ---- tb/annp_partner.sv ----
// annp_partner: negotiation side, loads partner pages and faults
// assumes tasks are called at the falling edge
`timescale 1ns/10ps
module annp_partner (
    input  wire logic   clk,
    output logic        pageLoad = 1'b0,
    output logic [15:0] pageWord = 16'h0000,
    output logic        pageIsNext = 1'b0,
    output logic        partnerNpAble = 1'b0,
    output logic        partnerAnAble = 1'b0,
    output logic        pdFaultAsync = 1'b0
);
    task automatic send(input logic [15:0] w, input logic nx, np, an);
        pageLoad = 1'b1;
        pageWord = w;
        pageIsNext = nx;
        partnerNpAble = np;
        partnerAnAble = an;
        @(negedge clk);
        pageLoad = 1'b0;
        pageWord = ~w; // word not held once loaded
    endtask : send
endmodule : annp_partner

// ---- tb/test_annp_regs.sv ----
// test_annp_regs: self-checking bench, bench acts as management
// assumes annp_partner supplies partner pages
`timescale 1ns/10ps
module test_annp_regs;
    logic        clk, rst, clkEn, regRd, regWr, rdSeen, txToggleLoad;
    logic        pageLoad, pageIsNext, partnerNpAble, partnerAnAble;
    logic        pdFaultAsync, txToggleValue, partnerWordIsNext;
    logic [4:0]  regAddr;
    logic [15:0] regWrData, regRdData, npTransmitWord, pageWord, w;
    logic [15:0] expQ[$];
    int          num_errors, total_checks;
    annp_regs    annp_regs_inst (.*);
    annp_partner annp_partner_inst (.*);
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    task automatic cmp(input string n, input logic [15:0] e, g);
        total_checks++;
        if (g !== e) begin
            num_errors++;
            $display("wrong value %s exp %h got %h", n, e, g);
        end
    endtask : cmp
    task automatic rd(input logic [4:0] a, input logic [15:0] e);
        expQ.push_back(e);
        regWr = 1'b0;
        regRd = 1'b1;
        regAddr = a;
        @(negedge clk);
    endtask : rd
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        regRd = 1'b0;
        regWr = 1'b1;
        regAddr = a;
        regWrData = d;
        @(negedge clk);
        regWr = 1'b0;
        @(negedge clk);
    endtask : wr
    task automatic end_sim;
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : end_sim
    // read results surface one edge after the request
    always @(posedge clk) rdSeen <= clkEn && regRd && !rst;
    always @(negedge clk) if (rdSeen) cmp("rd", expQ.pop_front(), regRdData);
    initial begin
        {rst, clkEn, regRd, regWr} = 4'hC;
        {regAddr, regWrData, txToggleLoad, txToggleValue} = 0;
        void'($urandom(83));
        repeat (4) @(negedge clk);
        rst = 1'b0;
        rd(5'h05, 16'h0000);
        rd(5'h06, 16'h0004);
        rd(5'h07, 16'h2001);
        rd(5'h00, 16'h0000);
        for (int i = 0; i < 6; i++) begin
            w = $urandom;
            regRd = 1'b0;
            @(negedge clk);
            annp_partner_inst.send(w, i[0], w[3], w[0]);
            if (i[0]) rd(5'h05, w);
            rd(5'h06, {12'h000, w[3], 2'b11, w[0]});
            rd(5'h06, {12'h000, w[3], 2'b10, w[0]});
        end
        annp_partner_inst.pdFaultAsync = 1'b1;
        regRd = 1'b0;
        repeat (8) @(negedge clk);
        rd(5'h06, {12'h001, w[3], 2'b10, w[0]});
        rd(5'h06, {12'h000, w[3], 2'b10, w[0]});
        for (int i = 0; i < 4; i++) begin
            w = $urandom;
            wr(5'h07, w);
            cmp("tx", w & 16'hBFFF, npTransmitWord);
        end
        rd(5'h07, w & 16'hBFFF);
        regRd = 1'b0;
        w = w & 16'hBFFF;
        txToggleValue = ~w[11];
        txToggleLoad = 1'b1;
        @(negedge clk);
        txToggleLoad = 1'b0;
        w[11] = ~w[11];
        cmp("toggle", w, npTransmitWord);
        clkEn = 1'b0;
        wr(5'h07, ~w);
        cmp("frozen", w, npTransmitWord);
        clkEn = 1'b1;
        repeat (2) @(negedge clk);
        end_sim();
    end
    initial begin
        repeat (2000) @(posedge clk);
        num_errors++;
        end_sim();
    end
endmodule : test_annp_regs
